// ===== logic/vfd_multiplex_dimming_driver.sv
`timescale 1ns/1ps
`default_nettype none
`include "vfd_timing_map.svh"
module vfd_multiplex_dimming_driver
  import vfd_types_pkg::*;
(
  input wire logic mclk,                  // 40 MHz system clock
  input wire logic reset_n,               // sync reset, low
  input wire logic chip_select,           // serial enable pin
  input wire logic shift_clk,             // serial shift clock pin
  input wire logic serial_data,           // serial data pin
  input wire logic duty_select,           // high 1/2, low 1/3
  input wire logic role_select,           // high master, low slave
  input wire logic brightness_pulse_in,   // dimming from master
  input wire logic sync_in_1,             // phase code from master
  input wire logic sync_in_2,             // phase code from master
  output logic [55:0] anode_out,          // segment drive, high lit
  output logic cathode_strobe_1_n,        // grid 1 select, low
  output logic cathode_strobe_2_n,        // grid 2 select, low
  output logic cathode_strobe_3_n,        // grid 3 select, low
  output logic brightness_pulse_out,      // dimming to slave
  output logic sync_out_1,                // phase code to slave
  output logic sync_out_2,                // phase code to slave
  output logic frame_ready                // buffer can take a frame
);

  localparam logic [5:0] BIT_LAST = 6'(`BIT_CYCLES - 1);

  // pin synchronisers
  logic [7:0] pin_meta;
  logic [7:0] pin_stable;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pin_meta <= 8'h00;
      pin_stable <= 8'h00;
    end else begin
      pin_meta <= {sync_in_2, sync_in_1, brightness_pulse_in,
        role_select, duty_select, serial_data, shift_clk,
        chip_select};
      pin_stable <= pin_meta;
    end
  end

  wire cs_s = pin_stable[0];
  wire sclk_s = pin_stable[1];
  wire data_s = pin_stable[2];
  wire duty_s = pin_stable[3];
  wire master_s = pin_stable[4];
  wire brightness_pulse_in_s = pin_stable[5];
  wire [1:0] sync_in_s = pin_stable[7:6];

  logic cs_prev;
  logic sclk_prev;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cs_prev <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      cs_prev <= cs_s;
      sclk_prev <= sclk_s;
    end
  end

  wire sclk_rise = sclk_s && !sclk_prev;
  wire shift_en = cs_s && sclk_rise;            // [RULE1] [RULE2]
  wire load_pulse = cs_prev && !cs_s;           // [RULE15]

  // serial input shift register
  frame_type shift_reg;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      shift_reg <= `RESET_FRAME;                // [RULE19]
    end else if (shift_en) begin
      shift_reg <= {shift_reg[BUF_WIDTH-2:0], data_s}; // [RULE3]
    end
  end

  // two-entry frame buffer; drained only on bit ticks
  frame_type buf_mem [BUF_DEPTH];
  logic buf_wr_ptr;
  logic buf_rd_ptr;
  logic [1:0] buf_count;
  logic bit_tick;

  wire buf_in_valid = load_pulse;
  wire buf_in_ready = (buf_count != 2'(BUF_DEPTH));
  wire buf_out_valid = (buf_count != 2'h0);
  wire buf_out_ready = bit_tick;
  wire push = buf_in_valid && buf_in_ready;
  wire pop = buf_out_valid && buf_out_ready;
  wire frame_type head = buf_mem[buf_rd_ptr];

  assign frame_ready = buf_in_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      buf_mem[buf_wr_ptr] <= shift_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      buf_wr_ptr <= 1'b0;
      buf_rd_ptr <= 1'b0;
      buf_count <= 2'h0;
    end else begin
      if (push) begin
        buf_wr_ptr <= !buf_wr_ptr;
      end
      if (pop) begin
        buf_rd_ptr <= !buf_rd_ptr;
      end
      buf_count <= buf_count + 2'(push) - 2'(pop);
    end
  end

  // frame decode: code in last three bits, payload first
  wire [2:0] head_code = head[`CODE_POS +: 3];  // [RULE16]
  anode_type head_anodes;
  logic [9:0] head_dim;
  genvar gi;
  generate
    for (gi = 0; gi < 56; gi++) begin : g_anode_bits
      assign head_anodes[gi] = head[`SEG_FIRST_POS - gi]; // [RULE17]
    end
    for (gi = 0; gi < 10; gi++) begin : g_dim_bits
      assign head_dim[gi] = head[`DIM_LSB_POS - gi]; // [RULE17]
    end
  endgenerate

  wire wr_all = pop && (head_code == `CODE_ALL);
  wire wr_g1 = pop && (head_code == `CODE_CATHODE_STROBE_1_N);
  wire wr_g2 = pop && (head_code == `CODE_CATHODE_STROBE_2_N);
  wire wr_g3 = pop && (head_code == `CODE_CATHODE_STROBE_3_N);
  wire wr_dim = pop && (head_code == `CODE_DIM);
  wire [2:0] seg_wr = {wr_g3, wr_g2, wr_g1} | {3{wr_all}};

  // segment latches, one per grid phase
  anode_type seg_latch [3];
  generate
    for (gi = 0; gi < 3; gi++) begin : g_latch
      always_ff @(posedge mclk) begin
        if (!reset_n) begin
          seg_latch[gi] <= `RESET_ANODES;       // [RULE19]
        end else if (seg_wr[gi]) begin
          seg_latch[gi] <= head_anodes;         // [RULE14]
        end
      end
    end
  endgenerate

  logic [9:0] dim_value;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dim_value <= `RESET_DIM;                  // [RULE19]
    end else if (wr_dim) begin
      dim_value <= head_dim;
    end
  end

  // bit time divider
  logic [5:0] bit_div;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bit_div <= 6'h00;
    end else if (bit_div == BIT_LAST) begin
      bit_div <= 6'h00;
    end else begin
      bit_div <= bit_div + 6'h01;
    end
  end
  assign bit_tick = (bit_div == BIT_LAST);      // [RULE13]

  // grid period position and phase
  logic [9:0] dim_pos;
  phase_type phase;
  phase_type next_phase;
  wire period_end = bit_tick && (dim_pos == 10'h3FF);

  always_comb begin
    unique case (phase)
      PHASE_1: next_phase = PHASE_2;
      PHASE_2: next_phase = duty_s ? PHASE_1 : PHASE_3; // [RULE4]
      PHASE_3: next_phase = PHASE_1;
      default: next_phase = PHASE_1;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dim_pos <= 10'h000;
      phase <= PHASE_1;
    end else if (bit_tick) begin
      dim_pos <= dim_pos + 10'h001;
      if (period_end) begin
        phase <= next_phase;
      end
    end
  end

  wire [9:0] dim_eff = (dim_value > `DIM_LIMIT) ? `DIM_LIMIT
    : dim_value;                                // [RULE20]
  wire master_on = (dim_pos < dim_eff);         // [RULE8] [RULE20]

  // master phase selection
  wire [2:0] master_grid = {phase == PHASE_3, phase == PHASE_2,
    phase == PHASE_1};
  wire [1:0] master_sync = (phase == PHASE_1) ? 2'b01
    : (phase == PHASE_2) ? 2'b10 : 2'b11;      // [RULE11]

  // slave phase selection from sync pins
  wire [2:0] slave_grid = {sync_in_s == 2'b11, sync_in_s == 2'b10,
    sync_in_s == 2'b01};                        // [RULE18]

  // role mux; master never reads dim or sync pins
  wire [2:0] sel_grid = master_s ? master_grid
    : slave_grid;                               // [RULE5] [RULE9]
  wire show = master_s ? master_on : brightness_pulse_in_s;  // [RULE6] [RULE7]
  wire anode_type sel_seg = ({56{sel_grid[0]}} & seg_latch[0])
    | ({56{sel_grid[1]}} & seg_latch[1])
    | ({56{sel_grid[2]}} & seg_latch[2]);

  wire anode_type next_anodes = show ? sel_seg : `RESET_ANODES;
  wire [2:0] next_strobe_n = (master_s && master_on) ? ~master_grid
    : 3'h7;                                     // [RULE12] [RULE18]
  wire next_bright_out = master_s && master_on; // [RULE10]
  wire [1:0] next_sync_out = master_s ? master_sync
    : 2'b00;                                    // [RULE11]

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      anode_out <= `RESET_ANODES;               // [RULE19]
      cathode_strobe_1_n <= 1'b1;
      cathode_strobe_2_n <= 1'b1;
      cathode_strobe_3_n <= 1'b1;
      brightness_pulse_out <= 1'b0;
      sync_out_1 <= 1'b0;
      sync_out_2 <= 1'b0;
    end else begin
      anode_out <= next_anodes;
      cathode_strobe_1_n <= next_strobe_n[0];
      cathode_strobe_2_n <= next_strobe_n[1];
      cathode_strobe_3_n <= next_strobe_n[2];
      brightness_pulse_out <= next_bright_out;
      sync_out_1 <= next_sync_out[0];
      sync_out_2 <= next_sync_out[1];
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  wire [2:0] strobes_n = {cathode_strobe_3_n, cathode_strobe_2_n,
    cathode_strobe_1_n};

  AST_CS_LOW_HOLDS: assert property ( // [RULE1]
    !cs_s |=> shift_reg == $past(shift_reg))
    else $error("shift register moved with select low");

  AST_SHIFT_CAPTURE: assert property ( // [RULE2] [RULE3]
    shift_en |=> shift_reg[0] == $past(data_s)
      && shift_reg[BUF_WIDTH-1:1] == $past(shift_reg[BUF_WIDTH-2:0]))
    else $error("serial bit not captured on clock rise");

  AST_DUPLEX_WRAP: assert property ( // [RULE4]
    master_s && duty_s && phase == PHASE_2 && period_end
      |=> phase == PHASE_1)
    else $error("duplex did not wrap after grid 2");

  AST_TRIPLEX_THIRD: assert property ( // [RULE4]
    !duty_s && phase == PHASE_2 && period_end |=> phase == PHASE_3)
    else $error("triplex skipped grid 3");

  AST_SLAVE_OUTS: assert property ( // [RULE18] [RULE5]
    !master_s |=> strobes_n == 3'h7 && !brightness_pulse_out
      && !sync_out_1 && !sync_out_2)
    else $error("slave drove grid, dim or sync output");

  AST_SLAVE_FOLLOW: assert property ( // [RULE6]
    !master_s && !brightness_pulse_in_s |=> anode_out == `RESET_ANODES)
    else $error("slave anodes lit without dim pulse");

  AST_MASTER_OFF: assert property ( // [RULE8] [RULE7] [RULE9]
    master_s && !master_on |=> anode_out == `RESET_ANODES
      && strobes_n == 3'h7 && !brightness_pulse_out)
    else $error("master outputs active outside dim window");

  AST_DIM_CEILING: assert property ( // [RULE20]
    master_s && dim_pos >= `DIM_LIMIT |=> !brightness_pulse_out)
    else $error("dim pulse beyond 1016 bit times");

  AST_SYNC_CODE: assert property ( // [RULE11] [RULE10]
    master_s && phase == PHASE_3 && master_on
      |=> sync_out_1 && sync_out_2 && brightness_pulse_out
        && !cathode_strobe_3_n)
    else $error("grid 3 phase code wrong");

  AST_STROBE_ONE: assert property ( // [RULE12]
    $onehot0(~strobes_n))
    else $error("more than one cathode strobe low");

  AST_BIT_TIME: assert property ( // [RULE13]
    bit_tick |=> (!bit_tick) [*8])
    else $error("bit ticks too close");

  AST_CATHODE_STROBE_1_N_LOAD: assert property ( // [RULE15] [RULE16] [RULE14]
    wr_g1 |=> seg_latch[0] == $past(head_anodes)
      && seg_latch[1] == $past(seg_latch[1]))
    else $error("grid 1 frame not latched alone");

  AST_DIM_LOAD: assert property ( // [RULE17]
    wr_dim |=> dim_value == $past(head_dim))
    else $error("dimming frame not latched");

  AST_LOAD_PUSH: assert property ( // [RULE15]
    load_pulse && buf_in_ready && !pop
      |=> buf_count == $past(buf_count) + 2'h1)
    else $error("chip select fall did not queue frame");

  AST_SLAVE_CATHODE_STROBE_2_N: assert property ( // [RULE18] [RULE6]
    !master_s && brightness_pulse_in_s && sync_in_s == 2'b10
      |=> anode_out == $past(seg_latch[1]))
    else $error("slave sync 01 did not show latch 2");

  AST_SLAVE_NONE: assert property ( // [RULE18]
    !master_s && sync_in_s == 2'b00 |=> anode_out == `RESET_ANODES)
    else $error("slave sync 00 lit anodes");

  AST_MASTER_CATHODE_STROBE_1_N: assert property ( // [RULE8] [RULE11] [RULE14]
    master_s && master_on && phase == PHASE_1
      |=> !cathode_strobe_1_n && anode_out == $past(seg_latch[0])
        && sync_out_1 && !sync_out_2)
    else $error("grid 1 phase outputs wrong");

  COV_DUPLEX_WRAP: cover property (
    master_s && duty_s && period_end && phase == PHASE_2);
  COV_SLAVE_CATHODE_STROBE_3_N: cover property (
    !master_s && sync_in_s == 2'b11 && brightness_pulse_in_s);
  COV_DIM_FRAME: cover property (wr_dim);
  COV_BUF_FULL: cover property (!buf_in_ready && load_pulse);
  COV_TRIPLEX_THIRD: cover property (
    master_s && !duty_s && period_end && phase == PHASE_2);

endmodule // vfd_multiplex_dimming_driver
`default_nettype wire

// ===== logic/vfd_timing_map.svh
// Function
// [RULE1] chip select low: ignore clock and data
// [RULE2] shift register advances on shift clock rise
// [RULE3] serial data high is captured as one
// [RULE4] duty pin high two grids, low three
// [RULE5] role pin high master, low slave
// [RULE6] slave anode width follows brightness pulse in
// [RULE7] master ignores brightness pulse input
// [RULE8] master widths from internal 10-bit dimmer
// [RULE9] master ignores both sync inputs
// [RULE10] drive brightness pulse out for slave
// [RULE11] two sync outputs encode grid phase
// [RULE12] cathode strobes are active low
// [RULE13] bit time is four oscillator periods
// [RULE14] segment latch held per grid phase
// [RULE15] chip select fall loads shift register
// [RULE16] payload first, code last, five codes
// [RULE17] 56 segment bits or 10 dimming bits lsb first
// [RULE18] slave decodes sync, grids high, outs low
// [RULE19] reset clears data, anodes low, grids high
// [RULE20] dimming active n of 1024, max 1016
`ifndef VFD_TIMING_MAP_SVH
`define VFD_TIMING_MAP_SVH
`define MCLK_KHZ 40000
`define OSC_KHZ 3300
`define OSC_PER_BIT 4
`define BIT_CYCLES ((`OSC_PER_BIT * `MCLK_KHZ) / `OSC_KHZ)
`define DIM_LIMIT 10'h3F8
`define CODE_ALL 3'h0
`define CODE_CATHODE_STROBE_1_N 3'h4
`define CODE_CATHODE_STROBE_2_N 3'h2
`define CODE_CATHODE_STROBE_3_N 3'h6
`define CODE_DIM 3'h1
`define CODE_POS 0
`define SEG_FIRST_POS 58
`define DIM_LSB_POS 12
`define RESET_ANODES 56'h0
`define RESET_DIM 10'h0
`define RESET_FRAME 59'h0
`endif

// ===== logic/vfd_types_pkg.sv
package vfd_types_pkg;
  localparam int BUF_WIDTH = 59;
  localparam int BUF_DEPTH = 2;
  typedef logic [BUF_WIDTH-1:0] frame_type;
  typedef logic [55:0] anode_type;
  typedef enum logic [1:0] {
    PHASE_1 = 2'b00,
    PHASE_2 = 2'b01,
    PHASE_3 = 2'b11
  } phase_type;
endpackage

// ===== test/vfd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module vfd_host_model (
  output logic chip_select, // serial enable to the device
  output logic shift_clk,   // link clock, still between frames
  output logic serial_data  // serial data, inverted once released
);
  initial begin
    chip_select = 1'b0;
    shift_clk = 1'b0;
    serial_data = 1'b0;
  end
  // sends n bits, top bit first; cs_on low clocks with select off
  task automatic shift_frame(input logic [58:0] f, input int n,
                             input logic cs_on);
    chip_select = cs_on;
    #213;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data = f[i];
      #100 shift_clk = 1'b1;
      #100 shift_clk = 1'b0;
    end
    #200 chip_select = 1'b0;
    serial_data = ~serial_data;
    #300;
  endtask
  // select pulse without clocks reloads the shift register as it is
  task automatic load_only(input int gap);
    chip_select = 1'b1;
    #(gap) chip_select = 1'b0;
    #(gap);
  endtask
endmodule // vfd_host_model
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vfd_types_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic duty_select = 1'b0;
  logic role_select = 1'b0;
  logic pulse_in = 1'b0;
  logic [1:0] sync_in = 2'b00;
  logic chip_select, shift_clk, serial_data;
  logic pulse_out, sync_out_1, sync_out_2, frame_ready;
  wire [2:0] strobe_n;
  anode_type anode_out;
  anode_type lat [3];
  wire [55:0] side_outs = {53'h0, pulse_out, sync_out_1, sync_out_2};
  int fails = 0;
  int num_checks = 0;

  always #12.5 mclk = ~mclk;

  vfd_host_model host (.chip_select(chip_select), .shift_clk(shift_clk),
    .serial_data(serial_data));
  vfd_multiplex_dimming_driver dut (.mclk(mclk), .reset_n(reset_n),
    .chip_select(chip_select), .shift_clk(shift_clk),
    .serial_data(serial_data), .duty_select(duty_select),
    .role_select(role_select), .brightness_pulse_in(pulse_in),
    .sync_in_1(sync_in[1]), .sync_in_2(sync_in[0]),
    .anode_out(anode_out), .cathode_strobe_1_n(strobe_n[0]),
    .cathode_strobe_2_n(strobe_n[1]), .cathode_strobe_3_n(strobe_n[2]),
    .brightness_pulse_out(pulse_out), .sync_out_1(sync_out_1),
    .sync_out_2(sync_out_2), .frame_ready(frame_ready));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic chk(input string name, input logic [55:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic logic [58:0] seg_frame(anode_type a, logic [2:0] c);
    logic [58:0] f;
    for (int k = 0; k < 56; k++) f[58-k] = a[k];
    f[2:0] = c;
    return f;
  endfunction
  function automatic logic [58:0] dim_frame(logic [9:0] d);
    logic [58:0] f = '0;
    for (int k = 0; k < 10; k++) f[12-k] = d[k];
    f[2:0] = 3'h1;
    return f;
  endfunction

  task automatic check_reset;
    chk("anodes", 56'h0, anode_out);
    chk("strobes", 56'h7, {53'h0, strobe_n});
    chk("outs", 56'h0, side_outs);
    chk("ready", 56'h1, {55'h0, frame_ready});
  endtask
  // each segment code and unused code 3, then each sync selection with the pulse on and off
  task automatic slave_latches;
    logic [2:0] codes [5] = '{3'h0, 3'h2, 3'h6, 3'h4, 3'h3};
    logic [1:0] sel [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
    anode_type p;
    anode_type e;
    for (int i = 0; i < 5; i++) begin
      p = (56'h0123456789ABCD << i) ^ 56'h80000000000001;
      host.shift_frame(seg_frame(p, codes[i]), 59, 1'b1);
      tick(60);
      if (codes[i] == 3'h0) lat = '{p, p, p};
      if (codes[i] == 3'h4) lat[0] = p;
      if (codes[i] == 3'h2) lat[1] = p;
      if (codes[i] == 3'h6) lat[2] = p;
      for (int s = 0; s < 4; s++) begin
        sync_in = sel[s];
        pulse_in = 1'b1;
        tick(5);
        e = s < 3 ? lat[s] : 56'h0;
        chk("slave seg", e, anode_out);
        chk("slave strobes", 56'h7, {53'h0, strobe_n});
        chk("slave outs", 56'h0, side_outs);
        pulse_in = 1'b0;
        tick(5);
        chk("pulse off", 56'h0, anode_out);
      end
    end
  endtask
  task automatic ignore_cs_low;
    host.shift_frame(seg_frame(~lat[0], 3'h4), 59, 1'b0);
    host.load_only(300);
    tick(60);
    sync_in = 2'b10;
    pulse_in = 1'b1;
    tick(5);
    chk("cs low", lat[0], anode_out);
  endtask
  // loads faster than bit ticks drain them
  task automatic fill_buffer;
    logic low_seen = 1'b0;
    int n = 0;
    fork
      repeat (4) host.load_only(100);
      repeat (40) begin
        tick(1);
        if (frame_ready === 1'b0) low_seen = 1'b1;
      end
    join
    chk("full", 56'h1, {55'h0, low_seen});
    while (frame_ready !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    chk("drained", 56'h1, {55'h0, frame_ready});
    if (frame_ready !== 1'b1) give_verdict();
  endtask
  // counts cycles while the strobes stay idle (all high) or stay lit
  task automatic wait_strobes(input logic idle, input int limit,
                              output int n);
    n = 0;
    while ((strobe_n === 3'h7) == idle && n < limit) begin
      tick(1);
      n++;
    end
    if (n >= limit) begin
      fails++;
      $display("BAD strobe wait expected change seen none");
      give_verdict();
    end
  endtask
  // outputs while the window of grid ph (0 to 2) is lit
  task automatic check_phase(input int ph);
    int sync_exp;
    sync_exp = ph == 0 ? 2 : (ph == 1 ? 1 : 3);
    chk("grid", {53'h0, ~(3'h1 << ph)}, {53'h0, strobe_n});
    chk("sync", sync_exp, {sync_out_1, sync_out_2});
    chk("brightness_pulse_out", 56'h1, {55'h0, pulse_out});
    chk("master seg", lat[ph], anode_out);
  endtask
  // 3 bit-time window, then a clamped value across the duplex wrap
  task automatic master_dimming;
    int n;
    int ph;
    host.shift_frame(dim_frame(10'h003), 13, 1'b1);
    tick(60);
    pulse_in = 1'b0;
    sync_in = 2'b11;
    duty_select = 1'b1;
    role_select = 1'b1;
    tick(5);
    wait_strobes(1'b0, 2000, n);
    wait_strobes(1'b1, 51000, n);
    ph = strobe_n[0] === 1'b0 ? 0 : (strobe_n[1] === 1'b0 ? 1 : 2);
    check_phase(ph);
    wait_strobes(1'b0, 2000, n);
    chk("width", 3 * 48, n);
    chk("off seg", 56'h0, anode_out);
    host.shift_frame(dim_frame(10'h3FF), 13, 1'b1);
    tick(60);
    wait_strobes(1'b1, 2000, n);
    wait_strobes(1'b0, 51000, n);
    wait_strobes(1'b1, 2000, n);
    chk("ceiling gap", 8 * 48, n);
    check_phase(ph == 0 ? 1 : 0);
  endtask

  initial begin
    tick(3);
    reset_n = 1'b1;
    tick(2);
    check_reset();
    slave_latches();
    ignore_cs_low();
    fill_buffer();
    master_dimming();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
